// ==== core/pgd_pkg.sv ====
// Shared constants for the dead-band PWM generator block.
package pgd_pkg;

   // Default structure of the block.
   localparam int GEN_NUM = 2;
   localparam int CNT_W = 16;
   localparam int DB_W = 12;
   localparam int EV_NUM = 6;
   localparam int ACT_W = 2;

   // Event positions inside the six-bit event and select vectors.
   localparam int EV_ZERO = 0;
   localparam int EV_LOAD = 1;
   localparam int EV_A_UP = 2;
   localparam int EV_A_DOWN = 3;
   localparam int EV_B_UP = 4;
   localparam int EV_B_DOWN = 5;

   // Two-bit action codes applied to a generator output on an event.
   localparam logic [1:0] ACT_KEEP = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_LOW = 2'h2;
   localparam logic [1:0] ACT_HIGH = 2'h3;

   // Reset values.
   localparam logic CNT_RST = 1'h0;
   localparam logic DIR_RST = 1'h1;
   localparam logic OUT_RST = 1'h0;
   localparam logic FAULT_RST = 1'h0;

endpackage

// ==== core/pgd_top.sv ====
// Multi-generator PWM unit with dead-band pairs, event triggers and output stage.
`timescale 1ns/1ns

//Contract
// - Down mode: load value down to zero, reload.
// - Up/down mode: triangle between zero and load.
// - Direction low in down mode, high ascending.
// - Zero and load pulses; load follows zero.
// - Compare match pulses, split by direction.
// - Match value above load never matches.
// - Four events down mode, six up/down.
// - Matches ignored when coinciding zero or load.
// - First output from A, second from B.
// - Per event action: keep, toggle, low, high.
// - Dead-band off: outputs pass unaltered.
// - Dead-band on: first output rising edge delayed.
// - Second output inverted, rising edge delayed.
// - Selectable event sets for interrupt and trigger.
// - Interrupt and trigger use undelayed events.
// - Global reset clears chosen counters together.
// - Immediate mode: new values apply at zero.
// - Sync mode: wait request, then apply zero.
// - Fault forces enabled outputs inactive, may interrupt.
// - Stall: keep running or halt at zero.
// - One enable vector gates each output.
// - Optional per-output final inversion.
// - Sixteen-bit counter, down or up/down mode.
// - Update request clears itself, not by software.
module pgd_top #(
   parameter int NUM_GEN = pgd_pkg::GEN_NUM,
   parameter int DBW = pgd_pkg::DB_W
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [NUM_GEN-1:0] gen_run_i,
   input wire logic [NUM_GEN-1:0] mode_updown_i,
   input wire logic [NUM_GEN-1:0] update_sync_mode_i,
   input wire logic [NUM_GEN-1:0] cfg_write_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::CNT_W-1:0] load_val_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::CNT_W-1:0] cmp_a_val_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::CNT_W-1:0] cmp_b_val_i,
   input wire logic [NUM_GEN-1:0] global_update_req_i,
   input wire logic [NUM_GEN-1:0] counter_reset_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::EV_NUM*pgd_pkg::ACT_W-1:0] act_first_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::EV_NUM*pgd_pkg::ACT_W-1:0] act_second_i,
   input wire logic [NUM_GEN-1:0] db_enable_i,
   input wire logic [NUM_GEN-1:0][DBW-1:0] db_rise_delay_i,
   input wire logic [NUM_GEN-1:0][DBW-1:0] db_fall_delay_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::EV_NUM-1:0] irq_select_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::EV_NUM-1:0] trig_select_i,
   input wire logic debug_stall_i,
   input wire logic [NUM_GEN-1:0] stall_halt_at_zero_i,
   input wire logic [2*NUM_GEN-1:0] out_enable_i,
   input wire logic [2*NUM_GEN-1:0] out_invert_i,
   input wire logic [2*NUM_GEN-1:0] fault_enable_i,
   input wire logic fault_irq_enable_i,
   input wire logic fault_i,
   output logic [2*NUM_GEN-1:0] pwm_pin_o,
   output logic [NUM_GEN-1:0] gen_irq_o,
   output logic [NUM_GEN-1:0] adc_trig_o,
   output logic fault_irq_o,
   output logic [NUM_GEN-1:0] global_update_pending_o,
   output logic [NUM_GEN-1:0][pgd_pkg::CNT_W-1:0] count_o,
   output logic [NUM_GEN-1:0] dir_up_o
);
   import pgd_pkg::*;

   // Refuse structures the logic cannot serve.
   if (NUM_GEN < 1 || DBW < 1 || DBW > CNT_W) begin : g_bad_param
      $error("pgd_top: NUM_GEN must be at least 1 and DBW within 1 to CNT_W");
   end

   // All state of the block in one record.
   typedef struct packed {
      logic [NUM_GEN-1:0][CNT_W-1:0] cnt;
      logic [NUM_GEN-1:0] dir;
      logic [NUM_GEN-1:0][CNT_W-1:0] act_load;
      logic [NUM_GEN-1:0][CNT_W-1:0] act_cmp_a;
      logic [NUM_GEN-1:0][CNT_W-1:0] act_cmp_b;
      logic [NUM_GEN-1:0][CNT_W-1:0] pend_load;
      logic [NUM_GEN-1:0][CNT_W-1:0] pend_cmp_a;
      logic [NUM_GEN-1:0][CNT_W-1:0] pend_cmp_b;
      logic [NUM_GEN-1:0] pend_dirty;
      logic [NUM_GEN-1:0] upd_req;
      logic [NUM_GEN-1:0] gen_out_first;
      logic [NUM_GEN-1:0] gen_out_second;
      logic [NUM_GEN-1:0] db_first;
      logic [NUM_GEN-1:0] db_second;
      logic [NUM_GEN-1:0][DBW-1:0] db_rise_cnt;
      logic [NUM_GEN-1:0][DBW-1:0] db_fall_cnt;
      logic [NUM_GEN-1:0] irq;
      logic [NUM_GEN-1:0] trig;
      logic [2*NUM_GEN-1:0] pre_pin;
      logic fault_meta;
      logic fault_sync;
   } pgd_state_s;

   pgd_state_s st;
   pgd_state_s next_st;

   // Applies one two-bit action code to the current output level.
   function automatic logic pgd_apply(input logic cur, input logic [1:0] act);
      logic res;
      res = cur;
      case (act)
         ACT_KEEP: res = cur;
         ACT_TOGGLE: res = ~cur;
         ACT_LOW: res = 1'h0;
         ACT_HIGH: res = 1'h1;
         default: res = cur;
      endcase
      return res;
   endfunction

   // Timing of one generator, edge by edge.
   // The count register is the time base; every event is
   // decoded from the count that stands in the current
   // cycle, so an event belongs to the cycle of its count.
   // The generator outputs change at the edge that ends the
   // event cycle, one cycle after the count was seen.
   // The dead-band stage looks at the registered generator
   // output, so it adds its own edge on top of that.
   // The pin register adds one more edge, which keeps every
   // pin free of decode glitches from the comparators.
   // The price is a fixed latency from count to pin, the
   // same for every event, so duty cycles are not skewed.
   //
   // Shadow values.
   // Writes land in the pending set only; the active set is
   // what the comparators and the reload use.
   // The swap happens solely in a ticking zero cycle, so a
   // period is never cut short or stretched by a write.
   // In synchronous mode the swap also needs the sticky
   // request, which clears itself in that same zero cycle.
   // A request that arrives in the clearing cycle survives,
   // so software can never lose a request to a race.
   //
   // Counter corner cases.
   // A load of zero parks the count at zero; zero and load
   // events then fire in every ticking cycle.
   // In up/down mode the turn at the peak goes straight to
   // load minus one, so the peak lasts exactly one cycle.
   // A global counter reset wins over counting, and puts
   // the direction to up only for up/down generators.
   //
   // Stall.
   // A generator set to halt keeps counting until zero and
   // then freezes; the frozen zero cycle gives no events,
   // so once frozen, a halted generator raises no interrupt or trigger.
   // A generator not set to halt simply keeps running.
   //
   // Limitation: the dead-band counters are only DBW bits
   // wide, so a delay can never exceed the DBW range.
   // Next-state logic for every generator and for the shared output stage.
   always_comb begin
      logic tick;
      logic at_zero;
      logic at_load;
      logic upd;
      logic match_a;
      logic match_b;
      logic [EV_NUM-1:0] ev;
      logic [CNT_W-1:0] new_load;
      logic fa;
      logic fb;
      logic raw_first;
      logic raw_second;
      tick = 1'h0;
      at_zero = 1'h0;
      at_load = 1'h0;
      upd = 1'h0;
      match_a = 1'h0;
      match_b = 1'h0;
      ev = '0;
      new_load = '0;
      fa = 1'h0;
      fb = 1'h0;
      raw_first = 1'h0;
      raw_second = 1'h0;
      next_st = st;

      // Two-stage synchroniser; only the second stage feeds logic.
      next_st.fault_meta = fault_i;
      next_st.fault_sync = st.fault_meta;

      for (int g = 0; g < NUM_GEN; g++) begin
         // A stalled generator set to halt freezes once it reaches zero.
         tick = gen_run_i[g] & ~(debug_stall_i & stall_halt_at_zero_i[g] & (st.cnt[g] == '0));

         // Raw counter events; they exist only in ticking cycles, when running and not halted at zero.
         at_zero = tick & (st.cnt[g] == '0);
         at_load = tick & (st.cnt[g] == st.act_load[g]);
         match_a = tick & (st.cnt[g] == st.act_cmp_a[g]) & (st.act_cmp_a[g] <= st.act_load[g]);
         match_b = tick & (st.cnt[g] == st.act_cmp_b[g]) & (st.act_cmp_b[g] <= st.act_load[g]);
         // A match that lands on zero or load is dropped.
         match_a = match_a & ~at_zero & ~at_load;
         match_b = match_b & ~at_zero & ~at_load;
         // Down mode keeps direction low, so the up events never fire there.
         ev[EV_ZERO] = at_zero;
         ev[EV_LOAD] = at_load;
         ev[EV_A_UP] = match_a & st.dir[g];
         ev[EV_A_DOWN] = match_a & ~st.dir[g];
         ev[EV_B_UP] = match_b & st.dir[g];
         ev[EV_B_DOWN] = match_b & ~st.dir[g];

         // Shadow values are swapped in only at zero so no pulse is cut short.
         if (update_sync_mode_i[g]) begin
            upd = at_zero & st.upd_req[g];
         end else begin
            upd = at_zero & st.pend_dirty[g];
         end
         new_load = upd ? st.pend_load[g] : st.act_load[g];
         if (upd) begin
            next_st.act_load[g] = st.pend_load[g];
            next_st.act_cmp_a[g] = st.pend_cmp_a[g];
            next_st.act_cmp_b[g] = st.pend_cmp_b[g];
         end
         // A new write in the very cycle of an update stays pending.
         if (cfg_write_i[g]) begin
            next_st.pend_load[g] = load_val_i[g];
            next_st.pend_cmp_a[g] = cmp_a_val_i[g];
            next_st.pend_cmp_b[g] = cmp_b_val_i[g];
         end
         next_st.pend_dirty[g] = cfg_write_i[g] | (st.pend_dirty[g] & ~upd);
         // The request is self-clearing at the applying zero; a new request wins.
         next_st.upd_req[g] = global_update_req_i[g] | (st.upd_req[g] & ~(at_zero & update_sync_mode_i[g]));

         // Counter; reset by the global control beats normal counting.
         if (counter_reset_i[g]) begin
            next_st.cnt[g] = '0;
            next_st.dir[g] = mode_updown_i[g];
         end else if (tick) begin
            if (!mode_updown_i[g]) begin
               next_st.dir[g] = 1'h0;
               if (st.cnt[g] == '0) begin
                  next_st.cnt[g] = new_load;
               end else begin
                  next_st.cnt[g] = CNT_W'(st.cnt[g] - 1'b1);
               end
            end else if (st.dir[g]) begin
               if (st.cnt[g] >= st.act_load[g]) begin
                  // Turn at the peak; a zero load keeps the count parked at zero.
                  next_st.dir[g] = (st.act_load[g] == '0);
                  next_st.cnt[g] = (st.act_load[g] == '0) ? st.cnt[g] : CNT_W'(st.act_load[g] - 1'b1);
               end else begin
                  next_st.cnt[g] = CNT_W'(st.cnt[g] + 1'b1);
               end
            end else begin
               if (st.cnt[g] == '0) begin
                  next_st.dir[g] = 1'h1;
                  next_st.cnt[g] = (new_load == '0) ? st.cnt[g] : CNT_W'(st.cnt[g] + 1'b1);
               end else begin
                  next_st.cnt[g] = CNT_W'(st.cnt[g] - 1'b1);
               end
            end
         end

         // Signal generator: zero, then load, then the output's own comparator.
         fa = st.gen_out_first[g];
         fb = st.gen_out_second[g];
         for (int e = 0; e < EV_NUM; e++) begin
            if (ev[e] && e != EV_B_UP && e != EV_B_DOWN) begin
               fa = pgd_apply(fa, act_first_i[g][e*ACT_W +: ACT_W]);
            end
            if (ev[e] && e != EV_A_UP && e != EV_A_DOWN) begin
               fb = pgd_apply(fb, act_second_i[g][e*ACT_W +: ACT_W]);
            end
         end
         next_st.gen_out_first[g] = fa;
         next_st.gen_out_second[g] = fb;

         // Dead-band: falling edges pass at once, rising edges wait their count.
         if (!st.gen_out_first[g]) begin
            next_st.db_first[g] = 1'h0;
            next_st.db_rise_cnt[g] = '0;
         end else if (!st.db_first[g]) begin
            if (st.db_rise_cnt[g] >= db_rise_delay_i[g]) begin
               next_st.db_first[g] = 1'h1;
            end else begin
               next_st.db_rise_cnt[g] = DBW'(st.db_rise_cnt[g] + 1'b1);
            end
         end
         if (st.gen_out_first[g]) begin
            next_st.db_second[g] = 1'h0;
            next_st.db_fall_cnt[g] = '0;
         end else if (!st.db_second[g]) begin
            if (st.db_fall_cnt[g] >= db_fall_delay_i[g]) begin
               next_st.db_second[g] = 1'h1;
            end else begin
               next_st.db_fall_cnt[g] = DBW'(st.db_fall_cnt[g] + 1'b1);
            end
         end

         // Trigger selector sees raw events, blind to dead-band shifts.
         next_st.irq[g] = |(ev & irq_select_i[g]);
         next_st.trig[g] = |(ev & trig_select_i[g]);

         // With dead-band on the second generator output is simply not used.
         raw_first = db_enable_i[g] ? st.db_first[g] : st.gen_out_first[g];
         raw_second = db_enable_i[g] ? st.db_second[g] : st.gen_out_second[g];
         next_st.pre_pin[2*g] = raw_first & out_enable_i[2*g];
         next_st.pre_pin[2*g+1] = raw_second & out_enable_i[2*g+1];
      end

      if (rst_i) begin
         next_st = '0;
         next_st.dir = {NUM_GEN{DIR_RST}};
         next_st.cnt = {NUM_GEN{{CNT_W{CNT_RST}}}};
         next_st.gen_out_first = {NUM_GEN{OUT_RST}};
         next_st.gen_out_second = {NUM_GEN{OUT_RST}};
         next_st.fault_meta = FAULT_RST;
         next_st.fault_sync = FAULT_RST;
      end
   end

   // Single state register; reset is handled synchronously in the next-state logic.
   always_ff @(posedge core_clk_i) begin
      st <= next_st;
   end

   // Fault masking is applied after the register so that a fault reaches the
   // pins two edges after it appears, without waiting for another pipeline stage.
   // Inactive means deasserted, so an inverted output sits high under fault.
   always_comb begin
      for (int k = 0; k < 2*NUM_GEN; k++) begin
         pwm_pin_o[k] = (st.pre_pin[k] & ~(st.fault_sync & fault_enable_i[k])) ^ out_invert_i[k];
      end
   end

   // Status and event outputs straight from the state record.
   assign fault_irq_o = st.fault_sync & fault_irq_enable_i;
   assign gen_irq_o = st.irq;
   assign adc_trig_o = st.trig;
   assign global_update_pending_o = st.upd_req;
   assign count_o = st.cnt;
   assign dir_up_o = st.dir;

endmodule

// ==== verification/pgd_chk.sv ====
// Port-level assertions for the PWM unit, watching generator 0 and the output stage.
`timescale 1ns/1ns
module pgd_chk #(
   parameter int NUM_GEN = 2
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [NUM_GEN-1:0] gen_run_i,
   input wire logic [NUM_GEN-1:0] mode_updown_i,
   input wire logic [NUM_GEN-1:0] global_update_req_i,
   input wire logic [NUM_GEN-1:0] counter_reset_i,
   input wire logic [NUM_GEN-1:0][pgd_pkg::EV_NUM-1:0] irq_select_i,
   input wire logic debug_stall_i,
   input wire logic [NUM_GEN-1:0] stall_halt_at_zero_i,
   input wire logic [2*NUM_GEN-1:0] out_enable_i,
   input wire logic [2*NUM_GEN-1:0] out_invert_i,
   input wire logic [2*NUM_GEN-1:0] fault_enable_i,
   input wire logic fault_irq_enable_i,
   input wire logic fault_i,
   input wire logic [2*NUM_GEN-1:0] pwm_pin_o,
   input wire logic [NUM_GEN-1:0] gen_irq_o,
   input wire logic fault_irq_o,
   input wire logic [NUM_GEN-1:0] global_update_pending_o,
   input wire logic [NUM_GEN-1:0][pgd_pkg::CNT_W-1:0] count_o,
   input wire logic [NUM_GEN-1:0] dir_up_o
);
   import pgd_pkg::*;
   // All checks share the PWM clock and stay quiet while reset is held.
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // A tick is a running, unstalled, uncleared cycle; only then must the counter move.
   logic tick0;
   assign tick0 = gen_run_i[0] & ~debug_stall_i & ~counter_reset_i[0];
   property p_dn_dec;
      tick0 && !mode_updown_i[0] && count_o[0] != 16'h0000 |=> count_o[0] == $past(count_o[0]) - 16'h0001;
   endproperty
   a_dn_dec: assert property (p_dn_dec) else $error("down count did not step by one");
   property p_ud_step;
      tick0 && mode_updown_i[0] && dir_up_o[0] |=> count_o[0] == 16'h0000 ||
         (dir_up_o[0] && count_o[0] == $past(count_o[0]) + 16'h0001) ||
         (!dir_up_o[0] && count_o[0] == $past(count_o[0]) - 16'h0001);
   endproperty
   a_ud_step: assert property (p_ud_step) else $error("triangle step wrong");
   property p_dir_dn;
      tick0 && !mode_updown_i[0] |=> !dir_up_o[0];
   endproperty
   a_dir_dn: assert property (p_dir_dn) else $error("direction high in down mode");
   property p_zero_irq;
      tick0 && irq_select_i[0] == 6'h01 && count_o[0] == 16'h0000 |=> gen_irq_o[0];
   endproperty
   a_zero_irq: assert property (p_zero_irq) else $error("zero event gave no interrupt");
   property p_irq_src;
      gen_irq_o[0] && $past(irq_select_i[0]) == 6'h01 |-> $past(count_o[0]) == 16'h0000;
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("interrupt without zero event");
   property p_stall;
      debug_stall_i && stall_halt_at_zero_i[0] && count_o[0] == 16'h0000 |=> count_o[0] == 16'h0000 && !gen_irq_o[0];
   endproperty
   a_stall: assert property (p_stall) else $error("halted counter moved or pulsed");
   property p_fault_irq;
      fault_i [*2] |=> fault_irq_o == fault_irq_enable_i;
   endproperty
   a_fault_irq: assert property (p_fault_irq) else $error("fault interrupt late or wrong");
   property p_fault_pin;
      fault_i [*2] ##1 fault_enable_i[0] |-> pwm_pin_o[0] == out_invert_i[0];
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("faulted pin not inactive");
   property p_pin_off;
      !$past(out_enable_i[1]) |-> pwm_pin_o[1] == out_invert_i[1];
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("disabled pin not idle");
   property p_upd_set;
      global_update_req_i[0] |=> global_update_pending_o[0];
   endproperty
   a_upd_set: assert property (p_upd_set) else $error("update request not held");
   property p_upd_hold;
      global_update_pending_o[0] && !(gen_run_i[0] && count_o[0] == 16'h0000) |=> global_update_pending_o[0];
   endproperty
   a_upd_hold: assert property (p_upd_hold) else $error("update request cleared early");
   // Main scenarios reached.
   c_fault: cover property (fault_irq_o);
   c_turn: cover property (dir_up_o[0] ##1 !dir_up_o[0]);
   c_upd: cover property (global_update_pending_o[0] ##1 !global_update_pending_o[0]);
endmodule

// ==== verification/pgd_bridge_model.sv ====
// Half-bridge driver model: flags overlapping gate drive and reports over-current on the fault line.
`timescale 1ns/1ns
module pgd_bridge_model (
   input wire logic core_clk_i,
   input wire logic high_side_i,
   input wire logic low_side_i,
   input wire logic trip_i,
   output logic fault_o,
   output logic overlap_o
);
   // The trip shows a clock late, as a real current comparator lags the load.
   always @(posedge core_clk_i) begin
      fault_o <= trip_i;
   end
   // Both switches on at once would short the rail.
   assign overlap_o = high_side_i & low_side_i;
endmodule

// ==== verification/pgd_tb_top.sv ====
// Self-checking bench for the PWM unit: counter shapes, actions, dead-band, pulses, updates, output stage, stall.
`timescale 1ns/1ns
module pgd_tb_top;
   import pgd_pkg::*;
   logic core_clk_i = 1'h0, rst_i = 1'h1, debug_stall_i = 1'h0, fault_irq_enable_i = 1'h1, trip = 1'h0;
   logic fault_i, fault_irq_o, overlap;
   logic [1:0] gen_run_i = 2'h0, mode_updown_i = 2'h0, update_sync_mode_i = 2'h0, cfg_write_i = 2'h0;
   logic [1:0] global_update_req_i = 2'h0, counter_reset_i = 2'h0, db_enable_i = 2'h0, stall_halt_at_zero_i = 2'h0;
   logic [1:0] gen_irq_o, adc_trig_o, global_update_pending_o, dir_up_o;
   logic [1:0][CNT_W-1:0] load_val_i = 32'h0, cmp_a_val_i = 32'h0, cmp_b_val_i = 32'h0, count_o;
   logic [1:0][EV_NUM*ACT_W-1:0] act_first_i = 24'h0, act_second_i = 24'h0;
   logic [1:0][DB_W-1:0] db_rise_delay_i = {2{12'h002}}, db_fall_delay_i = {2{12'h001}};
   logic [1:0][EV_NUM-1:0] irq_select_i = {2{6'h01}}, trig_select_i = {2{6'h02}};
   logic [3:0] out_enable_i = 4'hf, out_invert_i = 4'h0, fault_enable_i = 4'h0, pwm_pin_o;
   int fails = 0, comparisons = 0, cycles = 0, h0, h1, ni, nt, no, n;
   // Row: up/down mode, compare A, compare B, dead-band, expected high cycles of pins 0 and 1 per period.
   int rows [7][6] = '{'{0, 6, 3, 0, 4, 7}, '{0, 9, 3, 0, 10, 7}, '{0, 12, 3, 0, 10, 7}, '{0, 3, 3, 0, 7, 7},
      '{0, 6, 3, 1, 2, 5}, '{1, 6, 3, 0, 6, 15}, '{1, 12, 3, 0, 0, 15}};
   pgd_top i_dut (.core_clk_i, .rst_i, .gen_run_i, .mode_updown_i, .update_sync_mode_i, .cfg_write_i, .load_val_i,
      .cmp_a_val_i, .cmp_b_val_i, .global_update_req_i, .counter_reset_i, .act_first_i, .act_second_i, .db_enable_i,
      .db_rise_delay_i, .db_fall_delay_i, .irq_select_i, .trig_select_i, .debug_stall_i, .stall_halt_at_zero_i,
      .out_enable_i, .out_invert_i, .fault_enable_i, .fault_irq_enable_i, .fault_i, .pwm_pin_o, .gen_irq_o,
      .adc_trig_o, .fault_irq_o, .global_update_pending_o, .count_o, .dir_up_o);
   pgd_bridge_model i_bridge (.core_clk_i, .high_side_i(pwm_pin_o[0]), .low_side_i(pwm_pin_o[1]), .trip_i(trip),
      .fault_o(fault_i), .overlap_o(overlap));
   // Free-running 20 MHz clock.
   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end
   // Hang guard: the whole run needs well under a thousand cycles.
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s: got %0h, expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic do_reset();
      rst_i <= 1'h1;
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'h0;
   endtask
   // Both generators get the same values so their counters can be compared.
   task automatic write_vals(input logic [15:0] l, input logic [15:0] a, input logic [15:0] b);
      load_val_i <= {2{l}};
      cmp_a_val_i <= {2{a}};
      cmp_b_val_i <= {2{b}};
      cfg_write_i <= 2'h3;
      @(posedge core_clk_i);
      cfg_write_i <= 2'h0;
   endtask
   // Down mode uses keep, toggle, low and high; the toggles sit on the other output's match and must be ignored.
   task automatic setup(input int r);
      do_reset();
      mode_updown_i <= rows[r][0] ? 2'h3 : 2'h0;
      db_enable_i <= rows[r][3] ? 2'h3 : 2'h0;
      act_first_i <= rows[r][0] ? {2{12'h0b0}} : {2{12'h483}};
      act_second_i <= rows[r][0] ? {2{12'hb01}} : {2{12'h843}};
      write_vals(16'h0009, 16'(rows[r][1]), 16'(rows[r][2]));
      gen_run_i <= 2'h3;
      repeat (60) @(posedge core_clk_i);
   endtask
   // Window of whole periods, so the count does not depend on where it starts.
   task automatic measure(input int len);
      h0 = 0;
      h1 = 0;
      ni = 0;
      nt = 0;
      no = 0;
      repeat (len) begin
         @(negedge core_clk_i);
         h0 += int'(pwm_pin_o[0] === 1'h1);
         h1 += int'(pwm_pin_o[1] === 1'h1);
         ni += int'(gen_irq_o[0] === 1'h1);
         nt += int'(adc_trig_o[0] === 1'h1);
         no += int'(overlap === 1'h1);
      end
   endtask
   // Main sequence.
   initial begin
      foreach (rows[r]) begin
         setup(r);
         n = rows[r][0] ? 18 : 10;
         measure(n);
         check(16'(h0), 16'(rows[r][4]), "pin0 high");
         check(16'(h1), 16'(rows[r][5]), "pin1 high");
         check(16'(ni), 16'h0001, "irq pulses");
         check(16'(nt), 16'h0001, "trigger pulses");
         if (rows[r][3] != 0) check(16'(no), 16'h0000, "overlap");
         $display("row %0d done", r);
      end
      setup(0);
      counter_reset_i <= 2'h2;
      @(posedge core_clk_i);
      counter_reset_i <= 2'h0;
      repeat (3) @(posedge core_clk_i);
      counter_reset_i <= 2'h3;
      @(posedge core_clk_i);
      counter_reset_i <= 2'h0;
      repeat (3) @(posedge core_clk_i);
      @(negedge core_clk_i);
      check(count_o[0], 16'h0007, "count 0 after clear");
      check(count_o[1], 16'h0007, "count 1 after clear");
      $display("clear done");
      // Held values wait for the global request, then land at the next zero.
      update_sync_mode_i <= 2'h3;
      write_vals(16'h0009, 16'h0003, 16'h0003);
      repeat (20) @(posedge core_clk_i);
      measure(10);
      check(16'(h0), 16'h0004, "held compare");
      global_update_req_i <= 2'h3;
      @(posedge core_clk_i);
      global_update_req_i <= 2'h0;
      @(negedge core_clk_i);
      check(16'(global_update_pending_o), 16'h0003, "request set");
      repeat (12) @(posedge core_clk_i);
      check(16'(global_update_pending_o), 16'h0000, "request cleared");
      measure(10);
      check(16'(h0), 16'h0007, "new compare");
      $display("update done");
      out_invert_i <= 4'h1;
      out_enable_i <= 4'hd;
      @(posedge core_clk_i);
      measure(10);
      check(16'(h0), 16'h0003, "inverted pin");
      check(16'(h1), 16'h0000, "disabled pin");
      fault_enable_i <= 4'h1;
      trip <= 1'h1;
      repeat (4) @(posedge core_clk_i);
      measure(10);
      check(16'(h0), 16'h000a, "faulted pin");
      check(16'(fault_irq_o), 16'h0001, "fault irq");
      trip <= 1'h0;
      $display("output stage done");
      stall_halt_at_zero_i <= 2'h3;
      debug_stall_i <= 1'h1;
      repeat (20) @(posedge core_clk_i);
      measure(10);
      check(16'(ni + nt), 16'h0000, "pulses in stall");
      check(count_o[0], 16'h0000, "parked count");
      $display("stall done");
      summarize();
   end
endmodule
bind pgd_top pgd_chk #(.NUM_GEN(NUM_GEN)) i_chk (.core_clk_i, .rst_i, .gen_run_i, .mode_updown_i, .global_update_req_i,
   .counter_reset_i, .irq_select_i, .debug_stall_i, .stall_halt_at_zero_i, .out_enable_i, .out_invert_i,
   .fault_enable_i, .fault_irq_enable_i, .fault_i, .pwm_pin_o, .gen_irq_o, .fault_irq_o, .global_update_pending_o,
   .count_o, .dir_up_o);
